// [hdl/lgp_core.sv]
// led grayscale pwm control core: shift input, latch, pwm, axi4-lite
// assumes shift_clock_in is a free clock port from the controller that
// may stop between packets; clk is 100 MHz; resetn is async active low
// Operation
// - set 3 red/green/blue grayscale sit at bits 159-144/175-160/191-176
// - other grayscale fields are 16-bit, from bit 0, red-green-blue per set
// - brightness red 198-192, green 205-199, blue 212-206, per colour group
// - force-off bit 213 blanks outputs, clears counter, restarts timing
// - force-off bit comes up set after power-up
// - repeat bit 214 repeats the pattern every 65536 reference clocks
// - repetition runs only while the reference clock keeps running
// - repeat off runs one period after unblank or timing-reset latch
// - timing-reset bit 215: latch pulse clears counter, blanks outputs
// - timing-reset latch acts like toggling the force-off bit
// - timing-reset off: latch pulse leaves counter and outputs alone
// - bit 216 picks internal oscillator (0) or shift clock (1)
// - bit 217 switches outputs on rising (1) or falling (0) edge
// - latch after idle of 8x last interval, only with command 25h
// - idle before latch is clamped between 666 ns and 2.74 ms
// - latch pulse copies the 218 low shift bits into the latch
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "lgp_defs.svh"
module lgp_core
    import lgp_pkg::*;
#(
    parameter int IDLE_MIN_CYC = `LGP_IDLE_MIN_CYC,
    parameter int IDLE_MAX_CYC = `LGP_IDLE_MAX_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic shift_clock_in,
    input wire logic shift_data_in,
    output logic [`LGP_CHANNELS-1:0] sink_output,
    output logic [`LGP_BC_W-1:0] bright_red_group,
    output logic [`LGP_BC_W-1:0] bright_green_group,
    output logic [`LGP_BC_W-1:0] bright_blue_group,
    input wire logic [`LGP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LGP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int IW = $clog2(IDLE_MAX_CYC + 1);
    localparam logic [IW-1:0] IDLE_MAX = IW'(IDLE_MAX_CYC);
    localparam logic [IW-1:0] IDLE_MIN = IW'(IDLE_MIN_CYC);
    localparam int LW = `LGP_LATCH_W;
    localparam int PW = `LGP_PACKET_W;
    localparam logic [LW-1:0] LATCH_RST =
        {{(LW-`LGP_FORCE_OFF_BIT-1){1'b0}}, 1'b1,
         {`LGP_FORCE_OFF_BIT{1'b0}}};

    logic [PW-1:0] shift_r;
    logic sck_meta_r, sck_sync_r, sck_prev_r;
    logic [IW-1:0] itv_r, last_itv_r, thr_c;
    logic armed_r, latch_pulse_r, latch_done_r;
    logic [LW-1:0] latch_r;
    logic [LW-1:0] shift_low_c;
    logic cmd_ok_c;
    logic [15:0] osc_half_r, osc_cnt_r, latch_cnt_r;
    logic osc_lvl_r, osc_rise_r, osc_fall_r;
    logic ref_rise_c, ref_fall_c, restart_c, switch_evt_c, kill_c;
    logic force_off, repeat_en, timing_reset_en;
    logic ref_clock_select, switch_edge_select, force_prev_r;
    lgp_disp_t disp_r;
    logic [`LGP_GS_W-1:0] cnt_r, slot_r;
    logic act_r;

    // grayscale field of one channel, red-green-blue per output set
    function automatic logic [`LGP_GS_W-1:0] gs_of(
        input logic [LW-1:0] lat,
        input logic [3:0] idx
    );
        gs_of = lat[int'(idx) * `LGP_GS_W +: `LGP_GS_W];
    endfunction

    // idle limit: 8x the last interval, clamped to IDLE_MIN and IDLE_MAX
    function automatic logic [IW-1:0] idle_thr(input logic [IW-1:0] itv);
        logic [IW+2:0] x;
        x = {itv, 3'b000};
        if (x < {3'b000, IDLE_MIN}) begin
            idle_thr = IDLE_MIN;
        end else if (x > {3'b000, IDLE_MAX}) begin
            idle_thr = IDLE_MAX;
        end else begin
            idle_thr = x[IW-1:0];
        end
    endfunction

    // link side: the packet shifts in msb first on the controller's clock
    always_ff @(posedge shift_clock_in or negedge resetn) begin
        if (!resetn) begin
            shift_r <= '0;
        end else begin
            shift_r <= {shift_r[PW-2:0], shift_data_in};
        end
    end

    // the shift register is only read after the link has been idle for at
    // least IDLE_MIN cycles, so it is quasi-static when it crosses over
    assign shift_low_c = shift_r[LW-1:0];
    assign cmd_ok_c = shift_r[PW-1 -: `LGP_CMD_W] == `LGP_CMD_WRITE;
    assign thr_c = idle_thr(last_itv_r);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_meta_r <= 1'b0;
            sck_sync_r <= 1'b0;
            sck_prev_r <= 1'b0;
        end else begin
            sck_meta_r <= shift_clock_in;
            sck_sync_r <= sck_meta_r;
            sck_prev_r <= sck_sync_r;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            itv_r <= '0;
            last_itv_r <= IDLE_MAX;
            armed_r <= 1'b0;
            latch_pulse_r <= 1'b0;
            latch_done_r <= 1'b0;
        end else begin
            latch_pulse_r <= 1'b0;
            latch_done_r <= latch_pulse_r;
            if (sck_sync_r && !sck_prev_r) begin
                last_itv_r <= itv_r;
                itv_r <= '0;
                armed_r <= 1'b1;
            end else begin
                if (itv_r != IDLE_MAX) begin
                    itv_r <= itv_r + 1'b1;
                end
                if (armed_r && itv_r >= thr_c) begin
                    armed_r <= 1'b0;
                    latch_pulse_r <= cmd_ok_c;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= LATCH_RST;
            latch_cnt_r <= '0;
        end else if (latch_pulse_r) begin
            latch_r <= shift_low_c;
            latch_cnt_r <= latch_cnt_r + 1'b1;
        end
    end

    assign force_off = latch_r[`LGP_FORCE_OFF_BIT];
    assign repeat_en = latch_r[`LGP_REPEAT_BIT];
    assign timing_reset_en = latch_r[`LGP_TMG_RST_BIT];
    assign ref_clock_select = latch_r[`LGP_REF_SEL_BIT];
    assign switch_edge_select = latch_r[`LGP_EDGE_SEL_BIT];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bright_red_group <= '0;
            bright_green_group <= '0;
            bright_blue_group <= '0;
        end else begin
            bright_red_group <= latch_r[`LGP_BC_RED_LSB +: `LGP_BC_W];
            bright_green_group <= latch_r[`LGP_BC_GRN_LSB +: `LGP_BC_W];
            bright_blue_group <= latch_r[`LGP_BC_BLU_LSB +: `LGP_BC_W];
        end
    end

    // internal oscillator: square wave, half period set by software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_cnt_r <= '0;
            osc_lvl_r <= 1'b0;
            osc_rise_r <= 1'b0;
            osc_fall_r <= 1'b0;
        end else begin
            osc_rise_r <= 1'b0;
            osc_fall_r <= 1'b0;
            if (osc_cnt_r >= osc_half_r) begin
                osc_cnt_r <= '0;
                osc_lvl_r <= !osc_lvl_r;
                osc_rise_r <= !osc_lvl_r;
                osc_fall_r <= osc_lvl_r;
            end else begin
                osc_cnt_r <= osc_cnt_r + 1'b1;
            end
        end
    end

    assign ref_rise_c = ref_clock_select ? (sck_sync_r && !sck_prev_r)
                                         : osc_rise_r;
    assign ref_fall_c = ref_clock_select ? (!sck_sync_r && sck_prev_r)
                                         : osc_fall_r;
    // unblanking and a timing-reset latch both restart the period
    assign restart_c = (force_prev_r && !force_off) ||
                       (latch_done_r && timing_reset_en);
    assign kill_c = force_off || restart_c;
    assign switch_evt_c = switch_edge_select ? ref_rise_c : ref_fall_c;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            force_prev_r <= 1'b1;
            disp_r <= LGP_DSP_OFF;
            cnt_r <= '0;
            slot_r <= '0;
            act_r <= 1'b0;
        end else begin
            force_prev_r <= force_off;
            if (force_off) begin
                disp_r <= LGP_DSP_OFF;
                cnt_r <= '0;
                act_r <= 1'b0;
            end else if (restart_c) begin
                disp_r <= LGP_DSP_RUN;
                cnt_r <= '0;
                act_r <= 1'b0;
            end else if (ref_rise_c) begin
                // counting only on reference edges: a stopped clock freezes
                slot_r <= cnt_r;
                act_r <= disp_r == LGP_DSP_RUN;
                case (disp_r)
                    LGP_DSP_RUN: begin
                        if (cnt_r == `LGP_GS_LAST) begin
                            cnt_r <= '0;
                            if (!repeat_en) begin
                                disp_r <= LGP_DSP_DONE;
                            end
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    LGP_DSP_OFF, LGP_DSP_DONE: begin
                        cnt_r <= '0;
                    end
                    default: begin
                        disp_r <= LGP_DSP_OFF;
                    end
                endcase
            end
        end
    end

    // falling-edge mode uses the slot captured at the preceding rise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sink_output <= '0;
        end else if (kill_c) begin
            sink_output <= '0;
        end else if (switch_edge_select && ref_rise_c) begin
            for (int i = 0; i < `LGP_CHANNELS; i++) begin
                sink_output[i] <= (disp_r == LGP_DSP_RUN) &&
                    (gs_of(latch_r, 4'(i)) > cnt_r);
            end
        end else if (!switch_edge_select && ref_fall_c) begin
            for (int i = 0; i < `LGP_CHANNELS; i++) begin
                sink_output[i] <= act_r &&
                    (gs_of(latch_r, 4'(i)) > slot_r);
            end
        end
    end

    // axi4-lite write: address and data taken in either order
    logic aw_got_r, w_got_r;
    logic [`LGP_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LGP_RESP_OKAY;
            osc_half_r <= `LGP_OSC_HALF_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_r == `LGP_REG_CTRL) begin
                    s_axi_bresp <= LGP_RESP_OKAY;
                    if (w_strb_r[0]) begin
                        osc_half_r[7:0] <= w_data_r[7:0];
                    end
                    if (w_strb_r[1]) begin
                        osc_half_r[15:8] <= w_data_r[15:8];
                    end
                end else begin
                    s_axi_bresp <= LGP_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    logic [31:0] rd_data_c;
    logic rd_err_c;
    logic [`LGP_ADDR_W-1:0] gs_off_c;

    always_comb begin
        rd_data_c = '0;
        rd_err_c = 1'b0;
        gs_off_c = s_axi_araddr - `LGP_REG_GS_BASE;
        case (s_axi_araddr)
            `LGP_REG_CTRL: rd_data_c = {16'h0000, osc_half_r};
            `LGP_REG_STATUS: rd_data_c = {10'h000,
                latch_r[`LGP_FORCE_OFF_BIT +: `LGP_FC_W],
                disp_r == LGP_DSP_RUN, cnt_r};
            `LGP_REG_BRIGHT: rd_data_c = {11'h000,
                latch_r[`LGP_BC_RED_LSB +: 3 * `LGP_BC_W]};
            `LGP_REG_LATCHES: rd_data_c = {16'h0000, latch_cnt_r};
            default: begin
                if (s_axi_araddr >= `LGP_REG_GS_BASE &&
                    s_axi_araddr <= `LGP_REG_GS_LAST &&
                    s_axi_araddr[1:0] == 2'b00) begin
                    rd_data_c = {16'h0000, gs_of(latch_r, gs_off_c[5:2])};
                end else begin
                    rd_err_c = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= LGP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_c;
            s_axi_rresp <= rd_err_c ? LGP_RESP_SLVERR : LGP_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_idle_end;
        armed_r && !(sck_sync_r && !sck_prev_r) && itv_r >= thr_c;
    endsequence
    sequence s_period_end;
        disp_r == LGP_DSP_RUN && ref_rise_c && cnt_r == `LGP_GS_LAST &&
            !kill_c;
    endsequence

    latch_gate_a: assert property (
        s_idle_end |=> latch_pulse_r == $past(cmd_ok_c))
        else $error("latch pulse does not follow command check");
    latch_copy_a: assert property (
        latch_pulse_r |=> latch_r == $past(shift_low_c))
        else $error("latch did not take the low shift bits");
    idle_min_a: assert property (
        latch_pulse_r |-> itv_r > IDLE_MIN)
        else $error("latch pulse before minimum idle time");
    idle_max_a: assert property (
        armed_r && itv_r == IDLE_MAX && !(sck_sync_r && !sck_prev_r)
            |=> !armed_r)
        else $error("idle wait exceeded the maximum");
    force_off_a: assert property (
        force_off |=> sink_output == '0 && cnt_r == '0)
        else $error("force-off did not blank outputs");
    tmg_reset_a: assert property (
        restart_c && !force_off |=> sink_output == '0 && cnt_r == '0 &&
            disp_r == LGP_DSP_RUN)
        else $error("timing reset did not restart the period");
    no_tmg_a: assert property (
        latch_done_r && !timing_reset_en && !restart_c && !force_off &&
            !ref_rise_c |=> cnt_r == $past(cnt_r) &&
            disp_r == $past(disp_r))
        else $error("latch disturbed timing without timing reset");
    one_shot_a: assert property (
        s_period_end and !repeat_en |=> disp_r == LGP_DSP_DONE)
        else $error("single period did not stop");
    repeat_a: assert property (
        s_period_end and repeat_en |=> disp_r == LGP_DSP_RUN &&
            cnt_r == '0)
        else $error("repeat period did not wrap");
    edge_sel_a: assert property (
        sink_output != $past(sink_output) |->
            $past(switch_evt_c) || $past(kill_c))
        else $error("outputs switched off the selected edge");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before accepted");
endmodule

// [hdl/lgp_defs.svh]
// constants of the led grayscale pwm control core
// assumes a 100 MHz system clock and 32-bit axi4-lite register access
`ifndef LGP_DEFS_SVH
`define LGP_DEFS_SVH
`define LGP_GS_W 16
`define LGP_BC_W 7
`define LGP_CHANNELS 12
`define LGP_LATCH_W 218
`define LGP_PACKET_W 224
`define LGP_CMD_W 6
`define LGP_CMD_WRITE 6'h25
`define LGP_BC_RED_LSB 192
`define LGP_BC_GRN_LSB 199
`define LGP_BC_BLU_LSB 206
`define LGP_FORCE_OFF_BIT 213
`define LGP_REPEAT_BIT 214
`define LGP_TMG_RST_BIT 215
`define LGP_REF_SEL_BIT 216
`define LGP_EDGE_SEL_BIT 217
`define LGP_FC_W 5
`define LGP_GS_LAST 16'hffff
`define LGP_IDLE_SHIFT 3
`define LGP_CLK_PERIOD_NS 10
`define LGP_IDLE_MIN_NS 666
`define LGP_IDLE_MAX_NS 2740000
`define LGP_IDLE_MIN_CYC \
    ((`LGP_IDLE_MIN_NS + `LGP_CLK_PERIOD_NS - 1) / `LGP_CLK_PERIOD_NS)
`define LGP_IDLE_MAX_CYC (`LGP_IDLE_MAX_NS / `LGP_CLK_PERIOD_NS)
`define LGP_OSC_HALF_RST 16'h0004
`define LGP_ADDR_W 12
`define LGP_REG_CTRL 12'h000
`define LGP_REG_STATUS 12'h004
`define LGP_REG_BRIGHT 12'h008
`define LGP_REG_LATCHES 12'h00c
`define LGP_REG_GS_BASE 12'h040
`define LGP_REG_GS_LAST 12'h06c
`endif

// [hdl/lgp_pkg.sv]
// types of the led grayscale pwm control core
// assumes lgp_defs.svh is on the include path
package lgp_pkg;
    typedef enum logic [1:0] {
        LGP_DSP_OFF = 2'b00,
        LGP_DSP_RUN = 2'b01,
        LGP_DSP_DONE = 2'b10
    } lgp_disp_t;
    typedef enum logic [1:0] {
        LGP_RESP_OKAY = 2'b00,
        LGP_RESP_SLVERR = 2'b10
    } lgp_resp_t;
endpackage

// [verif/lgp_ctl_model.sv]
// serial controller model: shifts packets msb first on its own clock
// assumes the core samples data on the shift clock rising edge
`timescale 1ns/1ps
module lgp_ctl_model (
    output logic sck,
    output logic sdo
);
    initial begin
        sck = 1'h0;
        sdo = 1'h0;
    end
    // 15 ns link clock that runs only within a packet
    task automatic send(input logic [223:0] p);
        #3.3;
        for (int i = 223; i >= 0; i--) begin
            sdo = p[i];
            #7.5 sck = 1'h1;
            #7.5 sck = 1'h0;
        end
        // no pull on the data line, so leave the inverse behind
        sdo = ~p[0];
    endtask
endmodule

// [verif/test_led_gs_pwm_control.sv]
// self-checking bench for the led grayscale pwm control core
// assumes lgp_defs.svh on the include path and the axi map of the core
`timescale 1ns/1ps
`include "lgp_defs.svh"
module test_led_gs_pwm_control;
    import lgp_pkg::*;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic sck, sdo;
    logic [11:0] sink;
    logic [6:0] br_r, br_g, br_b;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v, c1;
    int mismatches = 0, checks_done = 0, cyc = 0, on0 = 0, on1 = 0;

    always #5 clk = ~clk;

    lgp_ctl_model ctl (.sck(sck), .sdo(sdo));

    // short idle ceiling keeps the bad-command wait brief
    lgp_core #(.IDLE_MAX_CYC(2000)) DUT (
        .clk(clk), .resetn(resetn), .shift_clock_in(sck),
        .shift_data_in(sdo), .sink_output(sink),
        .bright_red_group(br_r), .bright_green_group(br_g),
        .bright_blue_group(br_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    always @(posedge clk) begin
        on0 += int'(sink[0] === 1'h1);
        on1 += int'(sink[1] === 1'h1);
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            stop_test();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask

    task rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        v = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    function automatic logic [15:0] gs(int i);
        if (i < 3) return i == 0 ? 16'h0003 : i == 1 ? 16'h0000 : 16'hffff;
        return 16'h0101 * i[15:0];
    endfunction

    function automatic logic [223:0] mk(logic [5:0] cmd, logic [4:0] fc);
        logic [223:0] p;
        p = {cmd, fc, 7'h44, 7'h22, 7'h11, 192'h0};
        for (int i = 0; i < 12; i++) p[16*i +: 16] = gs(i);
        return p;
    endfunction

    // fc is {edge, ref, timing reset, repeat, force-off}
    task pkt(input logic [5:0] cmd, input logic [4:0] fc);
        logic [31:0] n;
        rd(`LGP_REG_LATCHES);
        n = v;
        @(negedge clk);
        on0 = 0;
        on1 = 0;
        ctl.send(mk(cmd, fc));
        repeat (40) @(posedge clk);
        rd(`LGP_REG_LATCHES);
        chk("early_latch", n, v);
        for (int t = 0; t < 60 && v == n; t++) rd(`LGP_REG_LATCHES);
        chk("latch_count", n + 32'(cmd == 6'h25), v);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
    end

    initial begin
        @(posedge resetn);
        chk("sink_rst", 0, sink);
        rd(`LGP_REG_STATUS);
        chk("status_rst", 32'h0002_0000, v);
        rd(12'h010);
        chk("unmapped", LGP_RESP_SLVERR, r);
        wr(`LGP_REG_STATUS, 32'h0000_ffff);
        chk("ro_write", LGP_RESP_SLVERR, r);
        wr(`LGP_REG_CTRL, 32'h0000_0001);
        rd(`LGP_REG_CTRL);
        chk("ctrl", 32'h0000_0001, v);
        pkt(6'h24, 5'h00);
        rd(`LGP_REG_STATUS);
        chk("status_bad_cmd", 32'h0002_0000, v);
        // oscillator period is 4 clk, so a value of 3 stays on 12 clk
        for (int e = 1; e >= 0; e--) begin
            pkt(6'h25, {e[0], 4'h6});
            for (int i = 0; i < 12; i++) begin
                rd(`LGP_REG_GS_BASE + 12'(4 * i));
                chk("gs", {16'h0, gs(i)}, v);
            end
            rd(`LGP_REG_BRIGHT);
            chk("bright", {11'h0, 21'h11_1111}, v);
            chk("bright_out", 21'h11_1111, {br_b, br_g, br_r});
            rd(`LGP_REG_STATUS);
            chk("fc", {e[0], 4'h6}, v[21:17]);
            repeat (200) @(posedge clk);
            chk("on_r0", 12, on0);
            chk("on_g0", 0, on1);
        end
        pkt(6'h25, 5'h13);
        repeat (50) @(posedge clk);
        rd(`LGP_REG_STATUS);
        chk("cnt_blank", 0, v[15:0]);
        chk("sink_blank", 0, sink);
        pkt(6'h25, 5'h12);
        repeat (2000) @(posedge clk);
        chk("on_unblank", 12, on0);
        rd(`LGP_REG_STATUS);
        c1 = v;
        pkt(6'h25, 5'h12);
        rd(`LGP_REG_STATUS);
        chk("cnt_kept", 1, v[15:0] > c1[15:0]);
        chk("no_restart", 0, on0);
        pkt(6'h25, 5'h16);
        rd(`LGP_REG_STATUS);
        chk("cnt_restart", 1, v[15:0] < 16);
        repeat (100) @(posedge clk);
        chk("on_restart", 12, on0);
        // shift clock as reference: stands still once the packet ends
        pkt(6'h25, 5'h1e);
        repeat (300) @(posedge clk);
        rd(`LGP_REG_STATUS);
        chk("cnt_ref_stop", 0, v[15:0]);
        pkt(6'h25, 5'h1a);
        rd(`LGP_REG_STATUS);
        chk("cnt_ref_run", 1, v[15:0] != 0 && v[15:0] <= 224);
        stop_test();
    end
endmodule
